// >>> hw/lsru_decode.v
`timescale 1ns/1ns
`include "lsru_map.vh"
// ****************************************
// Instruction class decode
// ****************************************
module lsru_decode (
  // Instruction
  input wire [31:0] instr,
  // Classes
  output reg is_load,
  output reg is_store,
  output reg is_resv,
  output reg is_ext,
  output reg use_imm,
  output reg [1:0] size,
  output reg legal
);
  wire [5:0] op = instr[31:26];
  wire [10:0] fn = instr[10:0];

  // Opcode and function decode
  always @* begin
    is_load = 1'b0;
    is_store = 1'b0;
    is_resv = 1'b0;
    is_ext = 1'b0;
    use_imm = 1'b0;
    size = 2'h2;
    legal = 1'b1;
    case (op)
      `LSRU_OP_LOAD_W, `LSRU_OP_STORE_W, `LSRU_OP_STORE_B,
      `LSRU_OP_STORE_H: begin
        is_load = (op == `LSRU_OP_LOAD_W);
        is_store = !is_load;
        size = (op == `LSRU_OP_STORE_B) ? 2'h0 :
               (op == `LSRU_OP_STORE_H) ? 2'h1 : 2'h2;
        is_ext = (fn == `LSRU_FN_EXT);
        is_resv = (fn == `LSRU_FN_RESV) &&
                  (op == `LSRU_OP_LOAD_W || op == `LSRU_OP_STORE_W);
        legal = is_ext || is_resv ||
                (is_store && (fn == `LSRU_FN_PLAIN ||
                              fn == `LSRU_FN_REV));
      end
      `LSRU_OP_LBI, `LSRU_OP_LHI, `LSRU_OP_LWI: begin
        is_load = 1'b1;
        use_imm = 1'b1;
        size = op[1:0];
      end
      `LSRU_OP_SBI, `LSRU_OP_SHI, `LSRU_OP_SWI: begin
        is_store = 1'b1;
        use_imm = 1'b1;
        size = op[1:0];
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end
endmodule

// >>> hw/lsru_map.vh
`ifndef LSRU_MAP_VH
`define LSRU_MAP_VH
// Primary opcodes, instruction bits 0-5 (word bits 31:26)
`define LSRU_OP_LOAD_W 6'h32
`define LSRU_OP_STORE_B 6'h34
`define LSRU_OP_STORE_H 6'h35
`define LSRU_OP_STORE_W 6'h36
`define LSRU_OP_LBI 6'h38
`define LSRU_OP_LHI 6'h39
`define LSRU_OP_LWI 6'h3a
`define LSRU_OP_SBI 6'h3c
`define LSRU_OP_SHI 6'h3d
`define LSRU_OP_SWI 6'h3e
// Function field, instruction bits 21-31 (word bits 10:0)
`define LSRU_FN_PLAIN 11'h000
`define LSRU_FN_REV 11'h200
`define LSRU_FN_EXT 11'h080
`define LSRU_FN_RESV 11'h400
// Barrier operands
`define LSRU_BAR_DATA 5'h01
`define LSRU_BAR_INSTR 5'h02
// Status register carry positions
`define LSRU_CARRY_FLAG_BIT 29
`define LSRU_MSR_CC_BIT 0
// Reset values
`define LSRU_RESV_RST 1'b0
`define LSRU_CARRY_RST 1'b0
`endif

// >>> hw/lsru_unit.v
`timescale 1ns/1ns
`include "lsru_map.vh"
// Notes on behaviour
// - Reserving load: word at Ra+Rb, sets reservation
// - Conditional store with reservation: store, carry 0
// - Without reservation: no store, carry 1
// - Word reservation, no unaligned exception raised
// - Store attempted even when address differs
// - One reservation, latest reserving load wins
// - Every conditional store clears the reservation
// - Reset, interrupt, exception, break clear reservation
// - Foreign write to reserved word kills reservation
// - Extended forms combine registers, not add
// - Immediate stores write byte, half, word
// - Immediate loads zero-extend byte and half
// - Barrier 1 waits for stores to land
// - Barrier 2 flushes prefetch and branch cache
// - Cache invalidate also empties stream buffers
// - Cache invalidate and flush privileged only
// - Carry at status bit 29, mirrored bit 0
module lsru_unit #(
  parameter AW = 32,
  parameter STORE_CNT_W = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Pipeline issue
  input wire issue_valid,
  input wire [31:0] instr,
  input wire [31:0] op_a,
  input wire [31:0] op_b,
  input wire [31:0] op_d,
  input wire [15:0] imm,
  input wire barrier_issue,
  input wire [4:0] barrier_op,
  input wire icache_inval_issue,
  input wire dcache_flush_issue,
  input wire user_mode,
  // Machine status
  input wire [31:0] msr_in,
  input wire msr_carry_we,
  input wire msr_carry_wdata,
  // Flush events
  input wire take_interrupt,
  input wire take_exception,
  input wire take_break,
  // Memory side
  input wire mem_ready,
  input wire [31:0] mem_rdata,
  input wire store_ack,
  input wire snoop_write,
  input wire [AW-1:0] snoop_addr,
  // Pipeline results
  output reg busy_ff,
  output reg done_ff,
  output reg rd_we_ff,
  output reg [31:0] rd_data_ff,
  output reg carry_ff,
  output reg carry_we_ff,
  output reg [31:0] msr_out_ff,
  output reg priv_fault_ff,
  output reg illegal_ff,
  // Memory requests
  output reg mem_req_ff,
  output reg mem_we_ff,
  output reg [AW-1:0] mem_addr_ff,
  output reg [31:0] mem_wdata_ff,
  output reg [3:0] mem_be_ff,
  // Cache maintenance
  output reg prefetch_flush_ff,
  output reg btc_clear_ff,
  output reg icache_inval_ff,
  output reg stream_flush_ff,
  output reg dcache_flush_ff,
  // Reservation view
  output reg resv_valid_ff
);
  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_MEM = 3'b010;
  localparam ST_BAR = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [AW-1:0] resv_addr_ff;
  reg [STORE_CNT_W-1:0] pend_ff;
  reg is_load_ff;
  reg [1:0] size_ff;
  reg [1:0] lane_ff;
  reg cond_ff;

  wire d_load;
  wire d_store;
  wire d_resv;
  wire d_ext;
  wire d_imm;
  wire [1:0] d_size;
  wire d_legal;

  // Class decode
  lsru_decode u_dec (
    .instr(instr),
    .is_load(d_load),
    .is_store(d_store),
    .is_resv(d_resv),
    .is_ext(d_ext),
    .use_imm(d_imm),
    .size(d_size),
    .legal(d_legal)
  );

  // ****************************************
  // Address and lanes
  // ****************************************
  wire [31:0] imm_sx = {{16{imm[15]}}, imm};
  wire [31:0] addr_sum = op_a + (d_imm ? imm_sx : op_b);
  wire [31:0] addr_ext = op_a & op_b;
  wire [31:0] addr_raw = d_ext ? addr_ext : addr_sum;
  // Reserving forms ignore low bits, so misalignment never traps
  wire [AW-1:0] addr = d_resv ? {addr_raw[AW-1:2], 2'h0} :
                       addr_raw[AW-1:0];
  wire go = issue_valid && state_ff == ST_IDLE && d_legal;
  wire swx = go && d_store && d_resv;
  wire swx_ok = swx && resv_valid_ff;
  wire load_word_reserve = go && d_load && d_resv;
  wire flush_evt = take_interrupt || take_exception || take_break;
  wire snoop_hit = snoop_write &&
                   snoop_addr[AW-1:2] == resv_addr_ff[AW-1:2];
  wire priv_bad = user_mode && (icache_inval_issue || dcache_flush_issue);

  // Byte enables per size and lane
  function [3:0] lsru_be;
    input [1:0] sz;
    input [1:0] ln;
    begin
      case (sz)
        2'h0: lsru_be = 4'h8 >> ln;
        2'h1: lsru_be = ln[1] ? 4'h3 : 4'hc;
        default: lsru_be = 4'hf;
      endcase
    end
  endfunction

  // Store data replicated across all lanes
  wire [31:0] wdata = (d_size == 2'h0) ? {4{op_d[7:0]}} :
                      (d_size == 2'h1) ? {2{op_d[15:0]}} : op_d;

  // Load data extraction, big-endian lanes
  wire [7:0] rbyte = mem_rdata[8*(3-lane_ff) +: 8];
  wire [15:0] rhalf = lane_ff[1] ? mem_rdata[15:0] : mem_rdata[31:16];
  wire [31:0] rload = (size_ff == 2'h0) ? {24'h0, rbyte} :
                      (size_ff == 2'h1) ? {16'h0, rhalf} :
                      mem_rdata;

  // ****************************************
  // Next state
  // ****************************************
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go && (d_load || d_store) && !(swx && !resv_valid_ff))
          nxt_state = ST_MEM;
        else if (issue_valid && barrier_issue &&
                 barrier_op == `LSRU_BAR_DATA)
          nxt_state = ST_BAR;
      end
      ST_MEM: begin
        if (mem_ready)
          nxt_state = ST_IDLE;
      end
      ST_BAR: begin
        if (pend_ff == {STORE_CNT_W{1'b0}})
          nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Reservation
  // ****************************************
  // Flush beats set; set beats the store and snoop clears
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resv_valid_ff <= `LSRU_RESV_RST;
      resv_addr_ff <= {AW{1'b0}};
    end else if (flush_evt) begin
      resv_valid_ff <= 1'b0;
    end else if (load_word_reserve) begin
      resv_valid_ff <= 1'b1;
      resv_addr_ff <= addr;
    end else if (swx || snoop_hit) begin
      resv_valid_ff <= 1'b0;
    end
  end

  // ****************************************
  // Outstanding store counter
  // ****************************************
  // Counts accepted writes not yet acknowledged by memory
  wire st_acc = state_ff == ST_MEM && mem_we_ff && mem_ready;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      pend_ff <= {STORE_CNT_W{1'b0}};
    else if (st_acc && !store_ack)
      pend_ff <= pend_ff + 1'b1;
    else if (store_ack && !st_acc && pend_ff != {STORE_CNT_W{1'b0}})
      pend_ff <= pend_ff - 1'b1;
  end

  // ****************************************
  // Main sequencing
  // ****************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rd_we_ff <= 1'b0;
      rd_data_ff <= 32'h0;
      carry_ff <= `LSRU_CARRY_RST;
      carry_we_ff <= 1'b0;
      priv_fault_ff <= 1'b0;
      illegal_ff <= 1'b0;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= {AW{1'b0}};
      mem_wdata_ff <= 32'h0;
      mem_be_ff <= 4'h0;
      is_load_ff <= 1'b0;
      size_ff <= 2'h2;
      lane_ff <= 2'h0;
      cond_ff <= 1'b0;
      prefetch_flush_ff <= 1'b0;
      btc_clear_ff <= 1'b0;
      icache_inval_ff <= 1'b0;
      stream_flush_ff <= 1'b0;
      dcache_flush_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state != ST_IDLE;
      done_ff <= 1'b0;
      rd_we_ff <= 1'b0;
      carry_we_ff <= 1'b0;
      priv_fault_ff <= 1'b0;
      illegal_ff <= 1'b0;
      prefetch_flush_ff <= 1'b0;
      btc_clear_ff <= 1'b0;
      icache_inval_ff <= 1'b0;
      stream_flush_ff <= 1'b0;
      dcache_flush_ff <= 1'b0;
      // Carry from other writers, conditional store overrides
      if (msr_carry_we)
        carry_ff <= msr_carry_wdata;
      if (issue_valid && state_ff == ST_IDLE && !d_legal &&
          !barrier_issue && !icache_inval_issue && !dcache_flush_issue)
        illegal_ff <= 1'b1;
      if (go && (d_load || d_store)) begin
        if (swx && !resv_valid_ff) begin
          carry_ff <= 1'b1;
          carry_we_ff <= 1'b1;
          done_ff <= 1'b1;
        end else begin
          mem_req_ff <= 1'b1;
          mem_we_ff <= d_store;
          mem_addr_ff <= addr;
          mem_wdata_ff <= wdata;
          mem_be_ff <= lsru_be(d_size, addr[1:0]);
          is_load_ff <= d_load;
          size_ff <= d_size;
          lane_ff <= addr[1:0];
          cond_ff <= swx_ok;
        end
      end
      if (state_ff == ST_MEM && mem_ready) begin
        mem_req_ff <= 1'b0;
        done_ff <= 1'b1;
        if (is_load_ff) begin
          rd_we_ff <= 1'b1;
          rd_data_ff <= rload;
        end
        if (cond_ff) begin
          carry_ff <= 1'b0;
          carry_we_ff <= 1'b1;
        end
      end
      if (state_ff == ST_BAR && pend_ff == {STORE_CNT_W{1'b0}})
        done_ff <= 1'b1;
      if (issue_valid && state_ff == ST_IDLE && barrier_issue &&
          barrier_op == `LSRU_BAR_INSTR) begin
        prefetch_flush_ff <= 1'b1;
        btc_clear_ff <= 1'b1;
        done_ff <= 1'b1;
      end
      if (issue_valid && state_ff == ST_IDLE && priv_bad) begin
        priv_fault_ff <= 1'b1;
      end else if (issue_valid && state_ff == ST_IDLE) begin
        icache_inval_ff <= icache_inval_issue;
        stream_flush_ff <= icache_inval_issue;
        dcache_flush_ff <= dcache_flush_issue;
      end
    end
  end

  // ****************************************
  // Status register view
  // ****************************************
  // Carry copy follows the live flag
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      msr_out_ff <= 32'h0;
    else begin
      msr_out_ff <= msr_in;
      msr_out_ff[`LSRU_CARRY_FLAG_BIT] <= carry_ff;
      msr_out_ff[`LSRU_MSR_CC_BIT] <= carry_ff;
    end
  end
endmodule

// >>> test/lsru_mem_model.sv
`timescale 1ns/1ns
// ************
// Data memory
// ************
module lsru_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pace
  input wire logic slow,
  // Request
  input wire logic mem_req_ff,
  input wire logic mem_we_ff,
  input wire logic [31:0] mem_addr_ff,
  input wire logic [31:0] mem_wdata_ff,
  input wire logic [3:0] mem_be_ff,
  // Answer
  output logic mem_ready,
  output logic [31:0] mem_rdata,
  output logic store_ack
);
  logic [31:0] mem [0:15];
  logic [1:0] wait_cnt;
  logic [3:0] ack_pipe;
  // Stores land late so a barrier has something to wait for
  assign store_ack = ack_pipe[3];
  // Distinct preset words
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'(32'h11111111 * i);
    end
  end
  // Read data toggles when idle so stale values never match
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_ready <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt <= 2'h0;
      ack_pipe <= 4'h0;
    end else begin
      ack_pipe <= {ack_pipe[2:0], mem_ready & mem_we_ff};
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_ff && !mem_ready) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt == {slow, 1'b0}) begin
          mem_ready <= 1'b1;
          wait_cnt <= 2'h0;
          mem_rdata <= mem[mem_addr_ff[5:2]];
          for (int i = 0; i < 4; i++) begin
            if (mem_we_ff && mem_be_ff[i])
              mem[mem_addr_ff[5:2]][8*i +: 8] <= mem_wdata_ff[8*i +: 8];
          end
        end
      end
    end
  end
endmodule

// >>> test/lsru_monitor.sv
`timescale 1ns/1ns
// ********
// Checker
// ********
module lsru_monitor #(
  parameter AW = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Issue side
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic barrier_issue,
  input wire logic [4:0] barrier_op,
  input wire logic icache_inval_issue,
  input wire logic user_mode,
  input wire logic take_interrupt,
  input wire logic take_exception,
  input wire logic take_break,
  // Results
  input wire logic busy_ff,
  input wire logic done_ff,
  input wire logic carry_ff,
  input wire logic carry_we_ff,
  input wire logic [31:0] msr_out_ff,
  input wire logic priv_fault_ff,
  input wire logic mem_req_ff,
  input wire logic mem_we_ff,
  input wire logic [AW-1:0] mem_addr_ff,
  input wire logic resv_valid_ff,
  input wire logic prefetch_flush_ff,
  input wire logic btc_clear_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Reserving ops taken; a flush in the same cycle wins over a set
  wire take = issue_valid && !busy_ff;
  wire flush = take_interrupt || take_exception || take_break;
  wire resv_op = take && instr[10:0] == 11'h400 && !flush;
  wire load_word_reserve = resv_op && instr[31:26] == 6'h32;
  wire swx = resv_op && instr[31:26] == 6'h36;
  wire bar2 = take && barrier_issue && barrier_op == 5'h02;

  lwx_set_a: assert property (load_word_reserve |=> resv_valid_ff)
    else $error("reserve not set");
  lwx_align_a: assert property (load_word_reserve |=> mem_req_ff && !mem_we_ff
    && mem_addr_ff[1:0] == 2'h0) else $error("reserve load address");
  swx_clear_a: assert property (swx |=> !resv_valid_ff)
    else $error("reserve kept after store");
  swx_fail_a: assert property (swx && !resv_valid_ff |=> done_ff
    && carry_we_ff && carry_ff && !mem_req_ff) else $error("failed store");
  swx_pass_a: assert property (swx && resv_valid_ff |=> mem_req_ff
    && mem_we_ff ##[1:8] (done_ff && carry_we_ff && !carry_ff))
    else $error("passed store");
  flush_clr_a: assert property (flush |=> !resv_valid_ff)
    else $error("reserve kept after flush");
  carry_copy_a: assert property ($stable(carry_ff) [*2] |->
    msr_out_ff[29] == carry_ff && msr_out_ff[0] == carry_ff)
    else $error("status carry copy");
  bar_instr_a: assert property (bar2 |=> prefetch_flush_ff
    && btc_clear_ff && done_ff) else $error("barrier two");
  priv_op_a: assert property (take && icache_inval_issue
    && user_mode |-> ##[1:4] priv_fault_ff) else $error("user inval");

  cover property (swx && resv_valid_ff);
  cover property (swx && !resv_valid_ff);
  cover property (flush && resv_valid_ff);
endmodule

bind lsru_unit lsru_monitor #(.AW(AW)) mon_u (.*);

// >>> test/lsru_unit_test.sv
`timescale 1ns/1ns
// ******
// Bench
// ******
module lsru_unit_test;
  logic clk_sys = 0, reset_n = 0, issue_valid = 0, barrier_issue = 0;
  logic user_mode = 0, snoop_write = 0, slow = 0;
  logic [2:0] flush = 0;
  logic [1:0] maint = 0;
  logic [4:0] barrier_op = 0;
  logic [15:0] imm = 0;
  logic [31:0] instr = 0, op_a = 0, op_b = 0, op_d = 0, snoop_addr = 0;
  logic [31:0] mem_rdata, mem_addr_ff, mem_wdata_ff, rd_data_ff, msr_out_ff;
  logic illegal_ff, icache_inval_ff, stream_flush_ff, dcache_flush_ff;
  logic [3:0] mem_be_ff;
  logic mem_ready, store_ack, busy_ff, done_ff, rd_we_ff, carry_ff;
  logic carry_we_ff, priv_fault_ff, mem_req_ff, mem_we_ff, resv_valid_ff;
  logic prefetch_flush_ff, btc_clear_ff;
  int errors = 0, compares = 0, cycles = 0, acks = 0;

  lsru_unit dut_u (.*, .icache_inval_issue(maint[0]),
    .dcache_flush_issue(maint[1]), .msr_in(32'h0), .msr_carry_we(1'b0),
    .msr_carry_wdata(1'b0), .take_interrupt(flush[0]),
    .take_exception(flush[1]), .take_break(flush[2]));
  lsru_mem_model mem_u (.*);

  // Clock and hang guard
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      results;
    end
  end
  // Count landed stores; tasks compare against a snapshot
  always @(posedge clk_sys) begin
    if (store_ack)
      acks <= acks + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
      errors++;
    if (seen !== exp)
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
  endtask

  function automatic logic [31:0] mw(input logic [31:0] a);
    return mem_u.mem[a[5:2]];
  endfunction

  // Issue one instruction and wait, bounded, for completion
  task automatic run(input logic [5:0] op, input logic [15:0] im,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] d);
    @(negedge clk_sys);
    instr = {op, 10'h0, im};
    imm = im;
    op_a = a;
    op_b = b;
    op_d = d;
    issue_valid = 1'b1;
    @(negedge clk_sys);
    issue_valid = 1'b0;
    for (int n = 0; n < 20; n++) begin
      if (done_ff === 1'b1 || priv_fault_ff === 1'b1)
        break;
      @(negedge clk_sys);
    end
    // A wait that runs out is a failure, never a silent pass
    if (done_ff !== 1'b1 && priv_fault_ff !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: no completion", $time);
    end
  endtask

  task automatic snoop(input logic [31:0] a);
    snoop_addr = a;
    snoop_write = 1'b1;
    @(negedge clk_sys);
    snoop_write = 1'b0;
  endtask

  // Failed store first, so the later carry of zero is a real change
  task automatic t_resv;
    run(6'h36, 16'h0400, 32'h24, 0, 32'h0bad0bad);
    check(carry_ff, 1);
    check(carry_we_ff, 1);
    check(mw(32'h24), 32'h99999999);
    @(negedge clk_sys);
    check(msr_out_ff, 32'h20000001);
    run(6'h32, 16'h0400, 32'h10, 32'h6, 0);
    check(rd_data_ff, 32'h55555555);
    check(mem_addr_ff, 32'h14);
    check(resv_valid_ff, 1);
    run(6'h36, 16'h0400, 32'h20, 0, 32'hcafe0001);
    check(carry_ff, 0);
    check(carry_we_ff, 1);
    check(mw(32'h20), 32'hcafe0001);
    check(resv_valid_ff, 0);
    $display("test resv done");
  endtask

  task automatic t_imm;
    logic [31:0] ra [3] = '{32'h40, 32'h38, 32'h10};
    logic [15:0] im [3] = '{16'hfffd, 16'h0002, 16'hfffc};
    logic [31:0] wm [3] = '{32'hffabffff, 32'heeeecdab, 32'h8765cdab};
    logic [31:0] ld [3] = '{32'hab, 32'hcdab, 32'h8765cdab};
    for (int k = 0; k < 3; k++) begin
      run(6'h3c | 6'(k), im[k], ra[k], 0, 32'h8765cdab);
      check(mw(ra[k] + {{16{im[k][15]}}, im[k]}), wm[k]);
      run(6'h38 | 6'(k), im[k], ra[k], 0, 0);
      check(rd_data_ff, ld[k]);
      check(rd_we_ff, 1);
    end
    $display("test imm done");
  endtask

  task automatic t_ext;
    logic [31:0] wx [3] = '{32'h44666666, 32'h33446666, 32'h11223344};
    for (int k = 0; k < 3; k++) begin
      run(6'h34 | 6'(k), 16'h0080, 32'h7c, 32'h1b, 32'h11223344);
      check(mw(32'h18), wx[k]);
    end
    run(6'h32, 16'h0080, 32'h7c, 32'h1b, 0);
    check(rd_data_ff, 32'h11223344);
    check(mw(32'h14), 32'h55555555);
    $display("test ext done");
  endtask

  task automatic t_sema;
    run(6'h32, 16'h0400, 32'h28, 0, 0);
    reset_n = 1'b0;
    @(negedge clk_sys);
    reset_n = 1'b1;
    check(resv_valid_ff, 0);
    for (int k = 0; k < 3; k++) begin
      run(6'h32, 16'h0400, 32'h28, 0, 0);
      flush[k] = 1'b1;
      @(negedge clk_sys);
      flush = 3'h0;
      check(resv_valid_ff, 0);
    end
    slow = 1'b1;
    run(6'h32, 16'h0400, 32'h2c, 0, 0);
    run(6'h32, 16'h0400, 32'h34, 0, 0);
    snoop(32'h2c);
    run(6'h36, 16'h0400, 32'h34, 0, 32'h5a5a);
    check(carry_ff, 0);
    run(6'h32, 16'h0400, 32'h34, 0, 0);
    snoop(32'h34);
    run(6'h36, 16'h0400, 32'h34, 0, 32'h1);
    check(carry_ff, 1);
    check(mw(32'h34), 32'h5a5a);
    $display("test sema done");
  endtask

  task automatic t_maint;
    int base;
    run(6'h3e, 16'h0004, 0, 0, 32'h77);
    base = acks;
    barrier_issue = 1'b1;
    barrier_op = 5'h01;
    run(6'h00, 16'h0, 0, 0, 0);
    check(acks - base, 1);
    barrier_op = 5'h02;
    run(6'h00, 16'h0, 0, 0, 0);
    check(btc_clear_ff, 1);
    check(prefetch_flush_ff, 1);
    barrier_issue = 1'b0;
    // Maintenance ops give no done, so their pulses are caught directly
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_sys);
      user_mode = k[1];
      maint = k[0] ? 2'h2 : 2'h1;
      issue_valid = 1'b1;
      @(negedge clk_sys);
      issue_valid = 1'b0;
      maint = 2'h0;
      check(priv_fault_ff, user_mode);
      check(icache_inval_ff, !user_mode && !k[0]);
      check(stream_flush_ff, !user_mode && !k[0]);
      check(dcache_flush_ff, !user_mode && k[0]);
      check(illegal_ff, 0);
    end
    $display("test maint done");
  endtask

  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset, then the scenarios
  initial begin
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    t_resv;
    t_imm;
    t_ext;
    t_sema;
    t_maint;
    results;
  end
endmodule
